// File: inc/dpll_ctl_pkg.sv
package dpll_ctl_pkg;
   // ==========================================
   // Bus and register map
   localparam int          ADDR_W           = 8;
   localparam logic [7:0]  OFF_CTRL         = 8'h00;
   localparam logic [7:0]  OFF_STATUS       = 8'h04;
   localparam logic [7:0]  OFF_FREE_LO      = 8'h08;
   localparam logic [7:0]  OFF_FREE_HI      = 8'h0c;
   localparam logic [7:0]  OFF_DEV_LO       = 8'h10;
   localparam logic [7:0]  OFF_DEV_HI       = 8'h14;
   localparam logic [7:0]  OFF_FBNUM_LO     = 8'h18;
   localparam logic [7:0]  OFF_FBNUM_HI     = 8'h1c;
   localparam logic [7:0]  OFF_UPDATE       = 8'h20;
   localparam logic [7:0]  OFF_EFFD_LO      = 8'h24;
   localparam logic [7:0]  OFF_EFFD_HI      = 8'h28;
   localparam logic [7:0]  OFF_EFFA_LO      = 8'h2c;
   localparam logic [7:0]  OFF_EFFA_HI      = 8'h30;
   localparam logic [7:0]  OFF_DEN_LO       = 8'h34;
   localparam logic [7:0]  OFF_DEN_HI       = 8'h38;
   localparam logic [7:0]  OFF_ANUM_LO      = 8'h3c;
   localparam logic [7:0]  OFF_ANUM_HI      = 8'h40;
   localparam logic [7:0]  OFF_STEP_SIZE    = 8'h44;
   // CTRL fields
   localparam int          CTRL_STEER_EN    = 0;
   localparam int          CTRL_HIST_EN     = 1;
   localparam int          CTRL_PIN_EN      = 2;
   // STATUS fields
   localparam int          ST_FLL           = 0;
   localparam int          ST_PLL           = 1;
   localparam int          ST_STATE_LSB     = 2;
   localparam int          ST_HIST_VALID    = 4;
   localparam int          ST_FEED_DONE     = 5;
   localparam int          ST_FAST_BW       = 6;
   // ==========================================
   // Widths and reset values
   localparam int          NUM_W            = 40;
   localparam int          DEV_W            = 38;
   localparam logic [39:0] DEN_RESET        = 40'h00_0000_0000;
   localparam logic [39:0] NUM_RESET        = 40'h00_0000_0000;
   localparam logic [31:0] STEP_SIZE_RESET  = 32'h0000_0100;
   // ==========================================
   // Trigger pin timing
   localparam int          CLK_MHZ          = 125;
   localparam int          TRIG_MIN_NS      = 100;
   localparam int          TRIG_MIN_CYC     = (TRIG_MIN_NS * CLK_MHZ + 999) / 1000;
   // ==========================================
   // Channel states
   typedef enum logic [1:0] {
      ST_FREE_RUN,
      ST_ACQUIRE,
      ST_LOCKED,
      ST_HOLDOVER
   } chan_state_t;
endpackage

// File: core/step_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
module step_edge_detect
   import dpll_ctl_pkg::*;
(
   input  wire logic clk,        // System clock
   input  wire logic reset_n,    // Async reset, active low
   input  wire logic trig_in,    // Trigger pin level
   input  wire logic dir_in,     // Direction pin level
   output logic      step_pulse, // One step taken
   output logic      step_down   // Direction of that step
);
   logic trig_q;
   logic dir_q;
   logic trig_prev_q;

   // ==========================================
   // Sampling
   // Both pins share one sampling stage so the direction matches its trigger
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trig_q      <= 1'b0;
         dir_q       <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         trig_q      <= trig_in;
         dir_q       <= dir_in;
         trig_prev_q <= trig_q;
      end
   end

   assign step_pulse = trig_q & ~trig_prev_q;
   assign step_down  = dir_q;
endmodule
`default_nettype wire

// File: core/free_run_feeder.sv
`timescale 1ns/10ps
`default_nettype none
module free_run_feeder
   import dpll_ctl_pkg::*;
(
   input  wire logic              clk,       // System clock
   input  wire logic              reset_n,   // Async reset, active low
   input  wire logic              load,      // New free-run word written
   input  wire logic [NUM_W-1:0]  word,      // Signed free-run word
   input  wire logic [31:0]       step_size, // Magnitude per step
   output logic                   busy,      // Steps still pending
   output logic                   done,      // Word fully applied (level)
   output logic signed [NUM_W-1:0] delta     // Signed step this cycle
);
   logic signed [NUM_W-1:0] rem_q;
   logic                    done_q;
   logic signed [NUM_W-1:0] sz;
   logic signed [NUM_W-1:0] neg_sz;

   assign sz     = signed'({8'h00, step_size});
   assign neg_sz = -sz;
   assign busy   = (rem_q != '0);
   assign done   = done_q;

   always_comb begin
      if (rem_q > sz)
         delta = sz;
      else if (rem_q < neg_sz)
         delta = neg_sz;
      else
         delta = rem_q;
   end

   // ==========================================
   // Remaining word; a fresh load drops what was left
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rem_q <= '0;
      end else if (load) begin
         rem_q <= signed'(word);
      end else begin
         rem_q <= rem_q - delta;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done_q <= 1'b0;
      end else if (load) begin
         done_q <= 1'b0;
      end else if (busy && (rem_q == delta)) begin
         done_q <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: core/dpll_state_and_dco_steering.sv
// Overview of operation
// - After configuration, lock analog loop to valid crystal input and free-run.
// - Reference lost after lock but without valid history enters free-run.
// - A valid reference in free-run or holdover starts lock acquisition.
// - Wide bandwidth during acquisition, normal bandwidth once acquisition completes.
// - Frequency- and phase-lock-lost flags visible as status bits and pins.
// - Frequency lock gained with history enabled starts history accumulation.
// - Reference lost with no other valid input enters holdover.
// - History disabled: holdover uses signed free-run word offset on numerator.
// - History not valid uses free-run word; valid history uses history word.
// - Holdover entry sets phase-lock-lost and freezes frequency-lock-lost.
// - Valid input in holdover leaves holdover and relocks without glitch.
// - Closed loop steers digital numerator; otherwise steers analog numerator.
// - Steering enable bit set to 1 enables digital steering, even locked.
// - Each relative step adds or subtracts 38-bit deviation word.
// - Step-update write always accepted: 0 steps up, 1 steps down.
// - Trigger pin rising edge applies one step; direction pin 1 is negative. In the code a pin step in the same cycle as a step-update write is dropped.
// - Clearing steering enable discards accumulated offset.
// - Writing the 40-bit feedback numerator sets digital frequency directly.
// - Denominator zero means two to the fortieth; deviation word unsigned.
// - Free-run word stepped when history enabled, else direct; readable back.
// - Free-run word is signed two's complement 40 bits.
// - New free-run word during stepping abandons remaining steps.
// - Completion flag set once free-run word fully fed.
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dpll_state_and_dco_steering
   import dpll_ctl_pkg::*;
(
   input  wire logic        CLK,           // 125 MHz clock
   input  wire logic        RESET_N,       // Async reset, active low
   input  wire logic        HSEL,          // AHB slave select
   input  wire logic [31:0] HADDR,         // AHB address
   input  wire logic [1:0]  HTRANS,        // AHB transfer type
   input  wire logic        HWRITE,        // AHB write
   input  wire logic [2:0]  HSIZE,         // AHB size
   input  wire logic [31:0] HWDATA,        // AHB write data
   input  wire logic        HREADY,        // AHB ready in
   output logic [31:0]      HRDATA,        // AHB read data
   output logic             HREADYOUT,     // AHB ready out
   output logic             HRESP,         // AHB response
   input  wire logic        XO_VALID,      // Crystal input valid
   input  wire logic        REF_VALID,     // At least one valid reference
   input  wire logic        FREQ_LOCKED,   // Frequency lock detector
   input  wire logic        PHASE_LOCKED,  // Phase lock detector
   input  wire logic        HIST_VALID,    // Tuning history valid
   input  wire logic [39:0] HIST_WORD,     // Averaged tuning word
   input  wire logic        STEP_TRIG,     // Step trigger pin
   input  wire logic        STEP_DIR,      // Step direction pin
   output logic             FLL_LOST,      // Frequency lock lost flag pin
   output logic             PLL_LOST,      // Phase lock lost flag pin
   output logic             APLL_LOCK_XO,  // Analog loop locking to crystal
   output logic             FAST_BW,       // Wide acquisition bandwidth
   output logic             HIST_ACCUM,    // History accumulation running
   output logic             DPLL_CLOSED,   // Digital loop drives analog loop
   output logic [39:0]      DPLL_NUM_EFF,  // Effective digital numerator
   output logic [39:0]      DPLL_DEN_EFF,  // Denominator, zero reads as max
   output logic [39:0]      APLL_NUM_EFF   // Effective analog numerator
);
   // ==========================================
   // Registers
   chan_state_t      state_q;
   logic             steer_en_q;
   logic             hist_en_q;
   logic             pin_en_q;
   logic [39:0]      free_word_q;
   logic [37:0]      dev_word_q;
   logic [39:0]      fb_num_q;
   logic [39:0]      den_q;
   logic [39:0]      anum_q;
   logic [31:0]      step_size_q;
   logic signed [39:0] dco_off_q;
   logic signed [39:0] afeed_q;
   logic             fll_q;
   logic             pll_q;
   logic             hist_acc_q;
   logic             wr_pend_q;
   logic             rd_pend_q;
   logic [7:0]       addr_q;
   logic [31:0]      rdata_q;

   logic             bus_take;
   logic             sw_step;
   logic             sw_down;
   logic             pin_step;
   logic             pin_down;
   logic             feed_load;
   logic             feed_load_q;
   logic             feed_busy;
   logic             feed_done;
   logic signed [39:0] feed_delta;
   logic signed [39:0] dev_s;
   logic [39:0]      hold_word;

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // ==========================================
   // AHB-Lite slave; zero wait states, always OKAY
   assign bus_take  = HSEL & HREADY & HTRANS[1];
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_q;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         wr_pend_q <= bus_take & HWRITE;
         rd_pend_q <= bus_take & ~HWRITE;
         if (bus_take)
            addr_q <= HADDR[ADDR_W-1:0];
      end
   end

   assign sw_step   = wr_pend_q & is_reg(addr_q, OFF_UPDATE);
   assign sw_down   = HWDATA[0];
   assign feed_load = wr_pend_q & (is_reg(addr_q, OFF_FREE_LO) | is_reg(addr_q, OFF_FREE_HI));

   // Word half lands on the write edge; feeding it then would restart from the old word
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         feed_load_q <= 1'b0;
      end else begin
         feed_load_q <= feed_load;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         steer_en_q  <= 1'b0;
         hist_en_q   <= 1'b0;
         pin_en_q    <= 1'b0;
         free_word_q <= NUM_RESET;
         dev_word_q  <= '0;
         den_q       <= DEN_RESET;
         anum_q      <= NUM_RESET;
         step_size_q <= STEP_SIZE_RESET;
      end else if (wr_pend_q) begin
         unique case (addr_q)
            OFF_CTRL: begin
               steer_en_q <= HWDATA[CTRL_STEER_EN];
               hist_en_q  <= HWDATA[CTRL_HIST_EN];
               pin_en_q   <= HWDATA[CTRL_PIN_EN];
            end
            OFF_FREE_LO:   free_word_q[31:0]  <= HWDATA;
            OFF_FREE_HI:   free_word_q[39:32] <= HWDATA[7:0];
            OFF_DEV_LO:    dev_word_q[31:0]   <= HWDATA;
            OFF_DEV_HI:    dev_word_q[37:32]  <= HWDATA[5:0];
            OFF_DEN_LO:    den_q[31:0]        <= HWDATA;
            OFF_DEN_HI:    den_q[39:32]       <= HWDATA[7:0];
            OFF_ANUM_LO:   anum_q[31:0]       <= HWDATA;
            OFF_ANUM_HI:   anum_q[39:32]      <= HWDATA[7:0];
            OFF_STEP_SIZE: step_size_q        <= HWDATA;
            default: ;
         endcase
      end
   end

   // Feedback numerator is written separately so absolute steering stays clear
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         fb_num_q <= NUM_RESET;
      end else if (wr_pend_q && is_reg(addr_q, OFF_FBNUM_LO)) begin
         fb_num_q[31:0] <= HWDATA;
      end else if (wr_pend_q && is_reg(addr_q, OFF_FBNUM_HI)) begin
         fb_num_q[39:32] <= HWDATA[7:0];
      end
   end

   // ==========================================
   // Channel state machine
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_q <= ST_FREE_RUN;
      end else begin
         unique case (state_q)
            ST_FREE_RUN:
               if (REF_VALID)
                  state_q <= ST_ACQUIRE;
            ST_ACQUIRE:
               if (!REF_VALID)
                  state_q <= ST_FREE_RUN;
               else if (FREQ_LOCKED && PHASE_LOCKED)
                  state_q <= ST_LOCKED;
            ST_LOCKED:
               if (!REF_VALID)
                  state_q <= HIST_VALID ? ST_HOLDOVER : ST_FREE_RUN;
            ST_HOLDOVER:
               if (REF_VALID)
                  state_q <= ST_ACQUIRE;
         endcase
      end
   end

   assign APLL_LOCK_XO = XO_VALID;
   assign FAST_BW      = (state_q == ST_ACQUIRE);
   assign DPLL_CLOSED  = (state_q == ST_ACQUIRE) | (state_q == ST_LOCKED);

   // ==========================================
   // Lock flags
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         fll_q <= 1'b1;
         pll_q <= 1'b1;
      end else begin
         if (state_q != ST_HOLDOVER)
            fll_q <= ~FREQ_LOCKED;
         if (state_q == ST_HOLDOVER || (state_q == ST_LOCKED && !REF_VALID))
            pll_q <= 1'b1;
         else
            pll_q <= ~PHASE_LOCKED;
      end
   end

   assign FLL_LOST = fll_q;
   assign PLL_LOST = pll_q;

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hist_acc_q <= 1'b0;
      end else begin
         hist_acc_q <= hist_en_q & DPLL_CLOSED & ~fll_q;
      end
   end

   assign HIST_ACCUM = hist_acc_q;

   // ==========================================
   // Digital loop relative steering
   step_edge_detect u_pins (
      .clk        (CLK),
      .reset_n    (RESET_N),
      .trig_in    (STEP_TRIG),
      .dir_in     (STEP_DIR),
      .step_pulse (pin_step),
      .step_down  (pin_down)
   );

   assign dev_s = signed'({2'b00, dev_word_q});

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         dco_off_q <= '0;
      end else if (!steer_en_q) begin
         dco_off_q <= '0;
      end else if (sw_step) begin
         dco_off_q <= sw_down ? dco_off_q - dev_s : dco_off_q + dev_s;
      end else if (pin_en_q && pin_step) begin
         dco_off_q <= pin_down ? dco_off_q - dev_s : dco_off_q + dev_s;
      end
   end

   assign DPLL_NUM_EFF = fb_num_q + dco_off_q;
   assign DPLL_DEN_EFF = den_q;                         // zero means full scale

   // ==========================================
   // Analog loop steering in holdover or free-run
   free_run_feeder u_feed (
      .clk       (CLK),
      .reset_n   (RESET_N),
      .load      (feed_load_q & hist_en_q),
      .word      (free_word_q),
      .step_size (step_size_q),
      .busy      (feed_busy),
      .done      (feed_done),
      .delta     (feed_delta)
   );

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         afeed_q <= '0;
      end else if (hist_en_q && feed_busy) begin
         afeed_q <= afeed_q + feed_delta;
      end
   end

   // Holdover frequency source
   always_comb begin
      if (hist_en_q && HIST_VALID)
         hold_word = HIST_WORD;
      else
         hold_word = free_word_q;
   end

   always_comb begin
      if (DPLL_CLOSED)
         APLL_NUM_EFF = DPLL_NUM_EFF;
      else if (state_q == ST_HOLDOVER && hist_en_q && HIST_VALID)
         APLL_NUM_EFF = anum_q + hold_word;
      else if (hist_en_q)
         APLL_NUM_EFF = anum_q + afeed_q;
      else
         APLL_NUM_EFF = anum_q + hold_word;
   end

   // ==========================================
   // Read data
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus_take && !HWRITE) begin
         unique case (HADDR[ADDR_W-1:0])
            OFF_CTRL:      rdata_q <= {29'h0, pin_en_q, hist_en_q, steer_en_q};
            OFF_STATUS:    rdata_q <= {25'h0, FAST_BW, feed_done, HIST_VALID,
                                       state_q, pll_q, fll_q};
            OFF_FREE_LO:   rdata_q <= free_word_q[31:0];
            OFF_FREE_HI:   rdata_q <= {24'h0, free_word_q[39:32]};
            OFF_DEV_LO:    rdata_q <= dev_word_q[31:0];
            OFF_DEV_HI:    rdata_q <= {26'h0, dev_word_q[37:32]};
            OFF_FBNUM_LO:  rdata_q <= fb_num_q[31:0];
            OFF_FBNUM_HI:  rdata_q <= {24'h0, fb_num_q[39:32]};
            OFF_EFFD_LO:   rdata_q <= DPLL_NUM_EFF[31:0];
            OFF_EFFD_HI:   rdata_q <= {24'h0, DPLL_NUM_EFF[39:32]};
            OFF_EFFA_LO:   rdata_q <= APLL_NUM_EFF[31:0];
            OFF_EFFA_HI:   rdata_q <= {24'h0, APLL_NUM_EFF[39:32]};
            OFF_DEN_LO:    rdata_q <= den_q[31:0];
            OFF_DEN_HI:    rdata_q <= {24'h0, den_q[39:32]};
            OFF_ANUM_LO:   rdata_q <= anum_q[31:0];
            OFF_ANUM_HI:   rdata_q <= {24'h0, anum_q[39:32]};
            OFF_STEP_SIZE: rdata_q <= step_size_q;
            default:       rdata_q <= 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: tb/dpll_steer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dpll_steer_chk (
   input  wire logic CLK,          // Clock
   input  wire logic RESET_N,      // Reset
   input  wire logic XO_VALID,     // Crystal ok
   input  wire logic REF_VALID,    // Reference ok
   input  wire logic FREQ_LOCKED,  // Freq detector
   input  wire logic PHASE_LOCKED, // Phase detector
   input  wire logic HIST_VALID,   // History ok
   input  wire logic FLL_LOST,     // Freq lost flag
   input  wire logic PLL_LOST,     // Phase lost flag
   input  wire logic APLL_LOCK_XO, // Analog to crystal
   input  wire logic FAST_BW,      // Acquiring
   input  wire logic DPLL_CLOSED,  // Loop closed
   input  wire logic HREADYOUT,    // Bus ready
   input  wire logic HRESP         // Bus response
);
   // ==========================================
   // Holdover tracker
   logic hold_q;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         hold_q <= 1'b0;
      else if (DPLL_CLOSED && !FAST_BW && !REF_VALID && HIST_VALID)
         hold_q <= 1'b1;
      else if (REF_VALID)
         hold_q <= 1'b0;
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_locked;
      DPLL_CLOSED && !FAST_BW;
   endsequence
   sequence s_ref_gone;
      s_locked ##0 !REF_VALID;
   endsequence
   xo_follow_a: assert property (APLL_LOCK_XO == XO_VALID)
      else $error("analog loop lock does not follow crystal");
   acq_start_a: assert property (!DPLL_CLOSED && REF_VALID |=> FAST_BW && DPLL_CLOSED)
      else $error("no acquisition on valid reference");
   acq_done_a: assert property (FAST_BW && REF_VALID && FREQ_LOCKED && PHASE_LOCKED |=> s_locked)
      else $error("acquisition did not complete");
   ref_loss_a: assert property (s_ref_gone |=> !DPLL_CLOSED)
      else $error("loop stayed closed without reference");
   hold_pll_a: assert property (s_ref_gone ##0 HIST_VALID |=> ##[0:1] PLL_LOST)
      else $error("phase lost flag not set in holdover");
   hold_fll_a: assert property (hold_q |=> $stable(FLL_LOST))
      else $error("freq lost flag moved in holdover");
   fll_track_a: assert property (DPLL_CLOSED && REF_VALID |=> FLL_LOST == !$past(FREQ_LOCKED))
      else $error("freq lost flag wrong");
   hold_exit_a: assert property (hold_q && REF_VALID |=> FAST_BW)
      else $error("holdover not left on reference");
   bus_okay_a: assert property (HREADYOUT && !HRESP)
      else $error("bus response not okay");
endmodule
`default_nettype wire

// File: tb/dpll_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dpll_host_model
   import dpll_ctl_pkg::*;
(
   input  wire logic        clk,    // Clock
   input  wire logic        hready, // Ready
   input  wire logic [31:0] hrdata, // Read data
   output logic             hsel,   // Select
   output logic [31:0]      haddr,  // Address
   output logic [1:0]       htrans, // Transfer
   output logic             hwrite, // Write
   output logic [2:0]       hsize,  // Size
   output logic [31:0]      hwdata, // Write data
   output logic             trig,   // Step trigger
   output logic             dir     // Step direction
);
   int n_tmo = 0;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      trig = 1'b0;
      dir = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int i;
      i = 0;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do begin @(posedge clk); i++; end while (!hready && i < 64);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); i++; end while (!hready && i < 128);
      q = hrdata;
      if (!hready)
         n_tmo++;
      #1;
   endtask
   // Trigger high and low long enough for the sampler, rate well under limit
   task automatic pin_step(input logic down);
      @(posedge clk);
      dir <= down;
      repeat (2) @(posedge clk);
      trig <= 1'b1;
      repeat (TRIG_MIN_CYC + 1) @(posedge clk);
      trig <= 1'b0;
      repeat (TRIG_MIN_CYC + 14) @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// File: tb/dpll_state_and_dco_steering_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dpll_state_and_dco_steering_bench;
   import dpll_ctl_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic xo_valid = 1'b1, ref_valid = 1'b0, freq_locked = 1'b0;
   logic phase_locked = 1'b0, hist_valid = 1'b0;
   logic hsel, hwrite, trig, dir, hreadyout, hresp, fll_lost, pll_lost;
   logic apll_lock_xo, fast_bw, hist_accum, dpll_closed;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rdata, junk;
   logic [39:0] dpll_num_eff, dpll_den_eff, apll_num_eff;
   int err_total = 0;
   int n_checks = 0;
   always #4 clk = ~clk;
   dpll_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .trig(trig), .dir(dir));
   dpll_state_and_dco_steering uut (.CLK(clk), .RESET_N(reset_n), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .XO_VALID(xo_valid), .REF_VALID(ref_valid), .FREQ_LOCKED(freq_locked),
      .PHASE_LOCKED(phase_locked), .HIST_VALID(hist_valid), .HIST_WORD(40'h12_3456),
      .STEP_TRIG(trig), .STEP_DIR(dir), .FLL_LOST(fll_lost), .PLL_LOST(pll_lost),
      .APLL_LOCK_XO(apll_lock_xo), .FAST_BW(fast_bw), .HIST_ACCUM(hist_accum),
      .DPLL_CLOSED(dpll_closed), .DPLL_NUM_EFF(dpll_num_eff),
      .DPLL_DEN_EFF(dpll_den_eff), .APLL_NUM_EFF(apll_num_eff));
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, junk);
   endtask
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, rdata);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      rd(OFF_STATUS);
      chk(rdata, 32'h3);
      rd(OFF_STEP_SIZE);
      chk(rdata, 32'h100);
      rd(8'h80);
      chk(rdata, 32'h0);
      chk(dpll_den_eff, 40'h0);
      @(posedge clk);
      xo_valid <= 1'b0;
      cyc(1);
      chk(apll_lock_xo, 1'b0);
      @(posedge clk);
      xo_valid <= 1'b1;
      cyc(1);
      chk(apll_lock_xo, 1'b1);
   endtask
   task automatic t_states();
      wr(OFF_CTRL, 32'h2);
      @(posedge clk);
      ref_valid <= 1'b1;
      cyc(1);
      chk(fast_bw, 1'b1);
      freq_locked <= 1'b1;
      phase_locked <= 1'b1;
      cyc(3);
      chk({fast_bw, dpll_closed, fll_lost, hist_accum}, 4'b0101);
      ref_valid <= 1'b0;
      hist_valid <= 1'b1;
      cyc(2);
      freq_locked <= 1'b0;
      cyc(3);
      chk({pll_lost, fll_lost}, 2'b10);
      chk(apll_num_eff, 40'h12_3456);
      rd(OFF_STATUS);
      chk(rdata[4:0], 5'h1e);
      freq_locked <= 1'b1;
      ref_valid <= 1'b1;
      cyc(1);
      chk(fast_bw, 1'b1);
      cyc(2);
      hist_valid <= 1'b0;
      ref_valid <= 1'b0;
      cyc(2);
      rd(OFF_STATUS);
      chk(rdata[3:2], 2'h0);
   endtask
   task automatic t_dco();
      ref_valid <= 1'b1;
      cyc(3);
      wr(OFF_DEV_LO, 32'h5);
      wr(OFF_FBNUM_LO, 32'h1000);
      chk(dpll_num_eff, 40'h1000);
      wr(OFF_CTRL, 32'h5);
      wr(OFF_UPDATE, 32'h0);
      chk(dpll_num_eff, 40'h1005);
      wr(OFF_UPDATE, 32'h1);
      wr(OFF_UPDATE, 32'h1);
      chk(dpll_num_eff, 40'hffb);
      chk(apll_num_eff, 40'hffb);
      host.pin_step(1'b0);
      chk(dpll_num_eff, 40'h1000);
      host.pin_step(1'b1);
      chk(dpll_num_eff, 40'hffb);
      wr(OFF_CTRL, 32'h4);
      cyc(1);
      chk(dpll_num_eff, 40'h1000);
   endtask
   task automatic t_apll();
      int i;
      ref_valid <= 1'b0;
      wr(OFF_ANUM_LO, 32'h1000);
      wr(OFF_CTRL, 32'h2);
      wr(OFF_FREE_LO, 32'h3000);
      rd(OFF_STATUS);
      chk(rdata[5], 1'b0);
      for (i = 0; i < 40 && !rdata[5]; i++)
         rd(OFF_STATUS);
      chk(rdata[5], 1'b1);
      chk(apll_num_eff, 40'h4000);
      wr(OFF_FREE_LO, 32'h8000);
      wr(OFF_FREE_LO, 32'h100);
      rd(OFF_STATUS);
      for (i = 0; i < 40 && !rdata[5]; i++)
         rd(OFF_STATUS);
      chk(apll_num_eff, 40'h4400);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_FREE_LO, 32'hffff_fff0);
      wr(OFF_FREE_HI, 32'hff);
      chk(apll_num_eff, 40'hff0);
      rd(OFF_EFFA_LO);
      chk(rdata, 32'hff0);
   endtask
   task automatic give_verdict();
      err_total += host.n_tmo;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_states();
      t_dco();
      t_apll();
      give_verdict();
   end
   initial begin
      repeat (50000) @(posedge clk);
      err_total++;
      give_verdict();
   end
endmodule
bind dpll_state_and_dco_steering dpll_steer_chk chk_i (.CLK(CLK), .RESET_N(RESET_N),
   .XO_VALID(XO_VALID), .REF_VALID(REF_VALID), .FREQ_LOCKED(FREQ_LOCKED),
   .PHASE_LOCKED(PHASE_LOCKED), .HIST_VALID(HIST_VALID), .FLL_LOST(FLL_LOST),
   .PLL_LOST(PLL_LOST), .APLL_LOCK_XO(APLL_LOCK_XO), .FAST_BW(FAST_BW),
   .DPLL_CLOSED(DPLL_CLOSED), .HREADYOUT(HREADYOUT), .HRESP(HRESP));
`default_nettype wire
